// >>> logic/rrb_pkg.sv
// Overview of operation
// - base field relocates block to 2K boundary
// - base bits are address bits 15..11
// - only lowest 512 bytes decode as block
// - base resets to zero, block at 0x0000
// - writable pull-up enables for input pins
// - writable reduced-drive selects per port
// - port G load: pin high up, low down
// - port H load: pin high up, low down
// - small package: port G always pulls up
// - small package: port H always pulls down
`default_nettype none
package rrb_pkg;

  // register indices; byte address is four times the index
  localparam logic [4:0] RRB_IDX_PULLUP    = 5'h0C;
  localparam logic [4:0] RRB_IDX_DRIVE     = 5'h0D;
  localparam logic [4:0] RRB_IDX_STATUS    = 5'h0E;
  localparam logic [4:0] RRB_IDX_BASE_INIT = 5'h11;
  localparam logic [6:0] RRB_ADDR_PULLUP    = {RRB_IDX_PULLUP, 2'b00};
  localparam logic [6:0] RRB_ADDR_DRIVE     = {RRB_IDX_DRIVE, 2'b00};
  localparam logic [6:0] RRB_ADDR_BASE_INIT = {RRB_IDX_BASE_INIT, 2'b00};

  // pull-up enable field positions
  localparam int RRB_PU_A = 0;
  localparam int RRB_PU_B = 1;
  localparam int RRB_PU_E = 4;
  localparam int RRB_PU_G = 6;
  localparam int RRB_PU_H = 7;

  // reduced-drive field positions
  localparam int RRB_LD_A = 0;
  localparam int RRB_LD_B = 1;
  localparam int RRB_LD_E = 3;
  localparam int RRB_LD_G = 5;
  localparam int RRB_LD_H = 6;

  // base init fields
  localparam int RRB_BASE_MSB  = 7;
  localparam int RRB_BASE_LSB  = 3;
  localparam int RRB_WAIT_STOP = 0;

  // status fields
  localparam int RRB_ST_G_POL = 0;
  localparam int RRB_ST_H_POL = 1;
  localparam int RRB_ST_SMALL = 2;
  localparam int RRB_ST_SEL   = 3;

  // reset values and writable masks
  localparam logic [7:0] RRB_PULLUP_RST    = 8'hD0;
  localparam logic [7:0] RRB_DRIVE_RST     = 8'h00;
  localparam logic [7:0] RRB_BASE_INIT_RST = 8'h00;
  localparam logic [7:0] RRB_PULLUP_MASK   = 8'hD3;
  localparam logic [7:0] RRB_DRIVE_MASK    = 8'h6B;
  localparam logic [7:0] RRB_BASE_MASK     = 8'hF9;

  // cpu address split
  localparam int RRB_ABASE_MSB = 15;
  localparam int RRB_ABASE_LSB = 11;
  localparam int RRB_AWIN_MSB  = 10;
  localparam int RRB_AWIN_LSB  = 9;
  localparam int RRB_AOFS_MSB  = 8;

  typedef struct packed {
    logic [6:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } rrb_avs_req_type;

  typedef struct packed {
    logic a_pu;
    logic b_pu;
    logic e_pu;
    logic g_pu;
    logic g_pd;
    logic h_pu;
    logic h_pd;
    logic a_ld;
    logic b_ld;
    logic e_ld;
    logic g_ld;
    logic h_ld;
  } rrb_pad_type;

  function automatic logic rrb_block_hit(input logic [15:0] addr, input logic [4:0] base);
    rrb_block_hit = (addr[RRB_ABASE_MSB:RRB_ABASE_LSB] == base) &&
                    (addr[RRB_AWIN_MSB:RRB_AWIN_LSB] == 2'b00);
  endfunction : rrb_block_hit

endpackage : rrb_pkg
`default_nettype wire

// >>> logic/rrb_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module rrb_sync2 (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // level in and out
  input  wire logic din,
  output logic      dout
);
  logic meta_r;
  logic meta_nxt;
  logic dout_nxt;

  // first stage feeds only the second
  always_comb begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      dout   <= dout_nxt;
    end
  end
endmodule : rrb_sync2
`default_nettype wire

// >>> logic/rrb_top.sv
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module rrb_top #(
  parameter bit SMALL_PKG = 1'b0
) (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  // avalon-mm slave
  input  wire rrb_pkg::rrb_avs_req_type avs_req,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  // cpu address decode and stop-in-wait copy
  input  wire logic [15:0]              cpu_addr,
  output logic                          block_sel,
  output logic [8:0]                    block_offset,
  output logic                          stop_in_wait,
  // pad control
  input  wire logic                     port_g_polarity_pin,
  input  wire logic                     port_h_polarity_pin,
  output rrb_pkg::rrb_pad_type          pad_ctrl
);
  import rrb_pkg::*;

  logic        req;
  logic        ack;
  logic        aligned;
  logic [4:0]  idx;
  logic        wr_lo;
  logic [7:0]  rd_byte;
  logic [31:0] readdata_nxt;
  logic        waitrequest_nxt;
  logic [7:0]  pullup_r;
  logic [7:0]  pullup_nxt;
  logic [7:0]  drive_r;
  logic [7:0]  drive_nxt;
  logic [7:0]  base_init_r;
  logic [7:0]  base_init_nxt;
  logic        sel_nxt;
  logic [8:0]  offset_nxt;
  rrb_pad_type pad_nxt;
  logic        g_pol_sync;
  logic        h_pol_sync;
  logic        g_pol;
  logic        h_pol;

  // polarity pins come from outside, so resync first
  rrb_sync2 u_sync_g (
    .core_clk (core_clk),
    .rstn     (rstn),
    .din      (port_g_polarity_pin),
    .dout     (g_pol_sync)
  );

  rrb_sync2 u_sync_h (
    .core_clk (core_clk),
    .rstn     (rstn),
    .din      (port_h_polarity_pin),
    .dout     (h_pol_sync)
  );

  // small package ties the pins internally
  assign g_pol = SMALL_PKG ? 1'b1 : g_pol_sync;
  assign h_pol = SMALL_PKG ? 1'b0 : h_pol_sync;

  assign req     = avs_req.read | avs_req.write;
  assign ack     = req & ~avs_waitrequest;
  assign idx     = avs_req.address[6:2];
  assign aligned = (avs_req.address[1:0] == 2'b00);
  assign wr_lo   = ack & avs_req.write & avs_req.byteenable[0] & aligned;

  // read mux; unmapped and misaligned read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (aligned) begin
      unique case (idx)
        RRB_IDX_PULLUP:    rd_byte = pullup_r;
        RRB_IDX_DRIVE:     rd_byte = drive_r;
        RRB_IDX_BASE_INIT: rd_byte = base_init_r;
        RRB_IDX_STATUS: begin
          rd_byte[RRB_ST_G_POL] = g_pol;
          rd_byte[RRB_ST_H_POL] = h_pol;
          rd_byte[RRB_ST_SMALL] = SMALL_PKG;
          rd_byte[RRB_ST_SEL]   = block_sel;
        end
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // one wait cycle per access; read data stands with the ack
  always_comb begin
    waitrequest_nxt = 1'b1;
    readdata_nxt    = 32'h0000_0000;
    if (req && avs_waitrequest) begin
      waitrequest_nxt = 1'b0;
      readdata_nxt    = {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= waitrequest_nxt;
      avs_readdata    <= readdata_nxt;
    end
  end

  // register writes take effect on the acked edge only
  always_comb begin
    pullup_nxt    = pullup_r;
    drive_nxt     = drive_r;
    base_init_nxt = base_init_r;
    if (wr_lo) begin
      unique case (idx)
        RRB_IDX_PULLUP:    pullup_nxt = avs_req.writedata[7:0] & RRB_PULLUP_MASK;
        RRB_IDX_DRIVE:     drive_nxt = avs_req.writedata[7:0] & RRB_DRIVE_MASK;
        RRB_IDX_BASE_INIT: base_init_nxt = avs_req.writedata[7:0] & RRB_BASE_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pullup_r    <= RRB_PULLUP_RST;
      drive_r     <= RRB_DRIVE_RST;
      base_init_r <= RRB_BASE_INIT_RST;
    end else begin
      pullup_r    <= pullup_nxt;
      drive_r     <= drive_nxt;
      base_init_r <= base_init_nxt;
    end
  end

  // registered decode costs a cycle but keeps outputs glitch free
  always_comb begin
    sel_nxt    = rrb_block_hit(cpu_addr, base_init_r[RRB_BASE_MSB:RRB_BASE_LSB]);
    offset_nxt = cpu_addr[RRB_AOFS_MSB:0];
  end

  // pad controls; pulls only matter on pins set as inputs
  always_comb begin
    pad_nxt.a_pu = pullup_r[RRB_PU_A];
    pad_nxt.b_pu = pullup_r[RRB_PU_B];
    pad_nxt.e_pu = pullup_r[RRB_PU_E];
    pad_nxt.g_pu = pullup_r[RRB_PU_G] & g_pol;
    pad_nxt.g_pd = pullup_r[RRB_PU_G] & ~g_pol;
    pad_nxt.h_pu = pullup_r[RRB_PU_H] & h_pol;
    pad_nxt.h_pd = pullup_r[RRB_PU_H] & ~h_pol;
    pad_nxt.a_ld = drive_r[RRB_LD_A];
    pad_nxt.b_ld = drive_r[RRB_LD_B];
    pad_nxt.e_ld = drive_r[RRB_LD_E];
    pad_nxt.g_ld = drive_r[RRB_LD_G];
    pad_nxt.h_ld = drive_r[RRB_LD_H];
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      block_sel    <= 1'b0;
      block_offset <= 9'h000;
      stop_in_wait <= 1'b0;
      pad_ctrl     <= '0;
    end else begin
      block_sel    <= sel_nxt;
      block_offset <= offset_nxt;
      stop_in_wait <= base_init_r[RRB_WAIT_STOP];
      pad_ctrl     <= pad_nxt;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_bus_take;
    req && avs_waitrequest;
  endsequence

  sequence s_bus_done;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  property p_bus_one_wait;
    s_bus_take |=> s_bus_done;
  endproperty
  a_bus_one_wait: assert property (p_bus_one_wait) else $error("bus ack not one cycle");

  property p_pullup_write;
    (ack && avs_req.write && avs_req.byteenable[0] && avs_req.address == RRB_ADDR_PULLUP)
      |=> pullup_r == ($past(avs_req.writedata[7:0]) & RRB_PULLUP_MASK)
          ##1 pad_ctrl.a_pu == pullup_r[RRB_PU_A];
  endproperty
  a_pullup_write: assert property (p_pullup_write) else $error("pull-up write lost");

  property p_drive_follow;
    (ack && avs_req.write && avs_req.byteenable[0] && avs_req.address == RRB_ADDR_DRIVE)
      |=> ##1 pad_ctrl.h_ld == $past(drive_r[RRB_LD_H]) &&
              pad_ctrl.b_ld == $past(drive_r[RRB_LD_B]);
  endproperty
  a_drive_follow: assert property (p_drive_follow) else $error("drive select wrong");

  property p_base_reset;
    $past(!rstn) && rstn |-> base_init_r == RRB_BASE_INIT_RST
      ##1 block_sel == ($past(cpu_addr) < 16'h0200);
  endproperty
  a_base_reset: assert property (p_base_reset) else $error("base not zero after reset");

  property p_ctrl_reset;
    $past(!rstn) |-> pullup_r == RRB_PULLUP_RST && drive_r == RRB_DRIVE_RST;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control reset value wrong");

  property p_relocate;
    (ack && avs_req.write && avs_req.byteenable[0] && avs_req.address == RRB_ADDR_BASE_INIT)
      |=> base_init_r[RRB_BASE_MSB:RRB_BASE_LSB] == $past(avs_req.writedata[7:3]);
  endproperty
  a_relocate: assert property (p_relocate) else $error("base field not written");

  property p_sel_match;
    block_sel |-> $past(cpu_addr[15:11]) == $past(base_init_r[7:3]) &&
                  $past(cpu_addr[10:9]) == 2'b00;
  endproperty
  a_sel_match: assert property (p_sel_match) else $error("select without match");

  // gated on rstn: the first edge out of reset still shows reset values
  property p_sel_hit;
    (rstn && cpu_addr[15:11] == base_init_r[7:3] && cpu_addr[10:9] == 2'b00) |=> block_sel;
  endproperty
  a_sel_hit: assert property (p_sel_hit) else $error("matching address missed");

  property p_upper_region;
    (rstn && cpu_addr[10:9] != 2'b00) |=> !block_sel;
  endproperty
  a_upper_region: assert property (p_upper_region) else $error("decode above 512 bytes");

  property p_g_polarity;
    rstn |=> pad_ctrl.g_pu == ($past(pullup_r[RRB_PU_G]) && $past(g_pol)) &&
             pad_ctrl.g_pd == ($past(pullup_r[RRB_PU_G]) && !$past(g_pol));
  endproperty
  a_g_polarity: assert property (p_g_polarity) else $error("port g pull direction wrong");

  property p_h_polarity;
    rstn |=> pad_ctrl.h_pu == ($past(pullup_r[RRB_PU_H]) && $past(h_pol)) &&
             pad_ctrl.h_pd == ($past(pullup_r[RRB_PU_H]) && !$past(h_pol));
  endproperty
  a_h_polarity: assert property (p_h_polarity) else $error("port h pull direction wrong");

  property p_small_g;
    SMALL_PKG |-> !pad_ctrl.g_pd;
  endproperty
  a_small_g: assert property (p_small_g) else $error("small package g pulled down");

  property p_small_h;
    SMALL_PKG |-> !pad_ctrl.h_pu;
  endproperty
  a_small_h: assert property (p_small_h) else $error("small package h pulled up");

  // readback; data stands only in the acked cycle
  property p_pullup_readback;
    (ack && avs_req.read && avs_req.address == RRB_ADDR_PULLUP)
      |-> avs_readdata == {24'h00_0000, $past(pullup_r)};
  endproperty
  a_pullup_readback: assert property (p_pullup_readback) else $error("pull-up readback");

  property p_drive_readback;
    (ack && avs_req.read && avs_req.address == RRB_ADDR_DRIVE)
      |-> avs_readdata == {24'h00_0000, $past(drive_r)};
  endproperty
  a_drive_readback: assert property (p_drive_readback) else $error("drive readback");

  property p_base_readback;
    (ack && avs_req.read && avs_req.address == RRB_ADDR_BASE_INIT)
      |-> avs_readdata == {24'h00_0000, $past(base_init_r)};
  endproperty
  a_base_readback: assert property (p_base_readback) else $error("base readback");

  property p_rdata_quiet;
    avs_waitrequest |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside ack");

  // a lane-off or misaligned write must not touch any control bit
  sequence s_refused_write;
    ack && avs_req.write && (!avs_req.byteenable[0] || avs_req.address[1:0] != 2'b00);
  endsequence

  property p_refused_write;
    s_refused_write |=> $stable(pullup_r) && $stable(drive_r) && $stable(base_init_r);
  endproperty
  a_refused_write: assert property (p_refused_write) else $error("refused write landed");

  property p_offset;
    rstn |=> block_offset == $past(cpu_addr[RRB_AOFS_MSB:0]);
  endproperty
  a_offset: assert property (p_offset) else $error("block offset wrong");

  property p_pad_reset;
    $past(!rstn) && rstn |=> !pad_ctrl.a_pu && !pad_ctrl.b_pu && pad_ctrl.e_pu &&
      (pad_ctrl.g_pu ^ pad_ctrl.g_pd) && (pad_ctrl.h_pu ^ pad_ctrl.h_pd) &&
      {pad_ctrl.a_ld, pad_ctrl.b_ld, pad_ctrl.e_ld, pad_ctrl.g_ld, pad_ctrl.h_ld} == 5'h00;
  endproperty
  a_pad_reset: assert property (p_pad_reset) else $error("pad reset state wrong");

  property p_stop_copy;
    rstn |=> stop_in_wait == $past(base_init_r[RRB_WAIT_STOP]);
  endproperty
  a_stop_copy: assert property (p_stop_copy) else $error("stop-in-wait copy wrong");

endmodule : rrb_top
`default_nettype wire

// >>> verif/rrb_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module rrb_top_test;
  import rrb_pkg::*;
  logic            core_clk;
  logic            rstn;
  rrb_avs_req_type avs_req;
  logic [31:0]     avs_readdata;
  logic            avs_waitrequest;
  logic [15:0]     cpu_addr;
  logic            block_sel;
  logic [8:0]      block_offset;
  logic            stop_in_wait;
  logic            g_pol;
  logic            h_pol;
  rrb_pad_type     pad_ctrl;
  rrb_pad_type     pad_small;
  integer          miscompares;
  integer          compares;
  integer          seed;
  logic [7:0]      pu_m;
  logic [7:0]      dr_m;
  logic [7:0]      bi_m;
  logic [31:0]     rd;
  logic [6:0]      ra [3];
  localparam logic [6:0] st_addr = {RRB_IDX_STATUS, 2'b00};

  rrb_top dut (
    .core_clk(core_clk), .rstn(rstn), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_addr(cpu_addr), .block_sel(block_sel), .block_offset(block_offset),
    .stop_in_wait(stop_in_wait), .port_g_polarity_pin(g_pol),
    .port_h_polarity_pin(h_pol), .pad_ctrl(pad_ctrl)
  );
  // small package sees the same bus traffic, so its registers track dut
  rrb_top #(.SMALL_PKG(1'b1)) dut_small (
    .core_clk(core_clk), .rstn(rstn), .avs_req(avs_req),
    .avs_readdata(), .avs_waitrequest(), .cpu_addr(cpu_addr),
    .block_sel(), .block_offset(), .stop_in_wait(),
    .port_g_polarity_pin(g_pol), .port_h_polarity_pin(h_pol),
    .pad_ctrl(pad_small)
  );

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic report_and_stop;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pad(input rrb_pad_type got, input rrb_pad_type exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t pad got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pad

  task automatic chk_dec(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t dec got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_dec

  // entered just after a rising edge; request stays up for back to back use
  task automatic bus(input logic wr, input logic [6:0] a, input logic [7:0] d,
                     input logic be, output logic [31:0] q);
    avs_req.address    <= a;
    avs_req.write      <= wr;
    avs_req.read       <= ~wr;
    avs_req.writedata  <= {24'h00_0000, d};
    avs_req.byteenable <= {3'h0, be};
    @(posedge core_clk);
    // no limit of its own; a hang is caught by the watchdog
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    q = avs_readdata;
  endtask : bus

  task automatic idle;
    avs_req.read  <= 1'b0;
    avs_req.write <= 1'b0;
    @(posedge core_clk);
  endtask : idle

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d, input logic be);
    bus(1'b1, a, d, be, rd);
    if (be && a == RRB_ADDR_PULLUP) pu_m = d & 8'hD3;
    if (be && a == RRB_ADDR_DRIVE) dr_m = d & 8'h6B;
    if (be && a == RRB_ADDR_BASE_INIT) bi_m = d & 8'hF9;
  endtask : wr_reg

  task automatic rd_chk(input logic [6:0] a);
    logic [7:0] e;
    e = (a == RRB_ADDR_PULLUP) ? pu_m : (a == RRB_ADDR_DRIVE) ? dr_m :
        (a == RRB_ADDR_BASE_INIT) ? bi_m : 8'h00;
    // status: model select, small flag clear, pins as synced
    if (a == st_addr) begin
      e = {4'h0, (cpu_addr[15:11] == bi_m[7:3]) && (cpu_addr[10:9] == 2'b00),
           1'b0, h_pol, g_pol};
    end
    bus(1'b0, a, 8'h00, 1'b1, rd);
    chk_reg(rd, {24'h00_0000, e});
  endtask : rd_chk

  task automatic dec_chk(input logic [15:0] a);
    cpu_addr <= a;
    @(posedge core_clk);
    @(negedge core_clk);
    chk_dec({block_sel, block_offset},
            {(a[15:11] == bi_m[7:3]) && (a[10:9] == 2'b00), a[8:0]});
    @(posedge core_clk);
  endtask : dec_chk

  function automatic rrb_pad_type exp_pad(input logic gp, input logic hp);
    rrb_pad_type p;
    p.a_pu = pu_m[0];
    p.b_pu = pu_m[1];
    p.e_pu = pu_m[4];
    p.g_pu = pu_m[6] & gp;
    p.g_pd = pu_m[6] & ~gp;
    p.h_pu = pu_m[7] & hp;
    p.h_pd = pu_m[7] & ~hp;
    p.a_ld = dr_m[0];
    p.b_ld = dr_m[1];
    p.e_ld = dr_m[3];
    p.g_ld = dr_m[5];
    p.h_ld = dr_m[6];
    return p;
  endfunction : exp_pad

  // pins go through two sync flops and an output flop, so allow four edges
  task automatic pad_chk;
    g_pol <= 1'($random(seed));
    h_pol <= 1'($random(seed));
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk_pad(pad_ctrl, exp_pad(g_pol, h_pol));
    chk_pad(pad_small, exp_pad(1'b1, 1'b0));
    chk_reg({31'h0, stop_in_wait}, {31'h0, bi_m[0]});
    @(posedge core_clk);
  endtask : pad_chk

  // used at start and after the random loop, so reset must undo random writes
  task automatic reset_run;
    rstn <= 1'b0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    pu_m = RRB_PULLUP_RST;
    dr_m = RRB_DRIVE_RST;
    bi_m = RRB_BASE_INIT_RST;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk_pad(pad_ctrl, exp_pad(g_pol, h_pol));
    chk_pad(pad_small, exp_pad(1'b1, 1'b0));
    @(posedge core_clk);
    foreach (ra[i]) rd_chk(ra[i]);
    idle();
  endtask : reset_run

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    seed = 44960;
    miscompares = 0;
    compares = 0;
    rstn = 1'b0;
    avs_req = '0;
    cpu_addr = 16'h0000;
    g_pol = 1'b1;
    h_pol = 1'b0;
    ra = '{RRB_ADDR_PULLUP, RRB_ADDR_DRIVE, RRB_ADDR_BASE_INIT};
    reset_run();
    dec_chk(16'h0000);
    dec_chk(16'h0200);
    for (int k = 0; k < 24; k++) begin
      foreach (ra[i]) wr_reg(ra[i], 8'($random(seed)), 1'b1);
      foreach (ra[i]) rd_chk(ra[i]);
      // refused forms: byte lane off, misaligned, unmapped
      wr_reg(RRB_ADDR_PULLUP, ~pu_m, 1'b0);
      wr_reg(RRB_ADDR_DRIVE + 7'h01, 8'hFF, 1'b1);
      wr_reg(7'h7C, 8'hFF, 1'b1);
      wr_reg(st_addr, 8'hFF, 1'b1);
      rd_chk(RRB_ADDR_PULLUP);
      rd_chk(RRB_ADDR_DRIVE + 7'h01);
      rd_chk(7'h7C);
      rd_chk(st_addr);
      idle();
      pad_chk();
      dec_chk({bi_m[7:3], 2'b00, 9'h000});
      dec_chk({bi_m[7:3], 2'b00, 9'h1FF});
      dec_chk({bi_m[7:3], 2'b01, 9'h000});
      dec_chk({bi_m[7:3], 2'b10, 9'h1FF});
      dec_chk({~bi_m[7:3], 2'b00, 9'h055});
      dec_chk(16'($random(seed)));
    end
    reset_run();
    dec_chk(16'h0000);
    report_and_stop();
  end
endmodule : rrb_top_test
`default_nettype wire
